// file: masd_pkg_rom.sv
// constants, slot types and the read-only information area store
`timescale 1ns/1ps

package masd_pkg;
  // register file map
  localparam logic [11:0] REG_RAM_BASE = 12'h000;
  localparam logic [11:0] REG_CTRL_BASE = 12'hF00;
  localparam logic [11:0] REG_CTRL_LAST = 12'hFFF;
  localparam logic [11:0] RAM_END_BIG = 12'h3FF;
  localparam logic [11:0] RAM_END_MID = 12'h1FF;
  localparam logic [11:0] RAM_END_SMALL = 12'h0FF;
  localparam int RAM_DEPTH = 1024;
  localparam logic [7:0] REG_UNDEF_BYTE = 8'h00;
  // program memory map
  localparam logic [15:0] FLASH_END_BIG = 16'h0FFF;
  localparam logic [15:0] FLASH_END_MID = 16'h07FF;
  localparam logic [15:0] FLASH_END_SMALL = 16'h03FF;
  localparam logic [7:0] PROG_UNIMPL_BYTE = 8'hFF;
  localparam logic [15:0] SLOT_RESET_VEC = 16'h0002;
  localparam logic [15:0] SLOT_WDOG_VEC = 16'h0004;
  localparam logic [15:0] SLOT_ILL_TRAP = 16'h0006;
  localparam logic [15:0] SLOT_IRQ_VEC = 16'h0008;
  localparam logic [15:0] SLOT_OSC_TRAP = 16'h0038;
  localparam logic [15:0] SLOT_CODE = 16'h003E;
  // information area overlay
  localparam logic [15:0] INFO_BASE = 16'hFE00;
  localparam logic [15:0] INFO_LAST = 16'hFF7F;
  localparam logic [7:0] INFO_SIZE = 8'h80;
  localparam logic [6:0] INFO_PART_ID = 7'h40;
  localparam logic [6:0] INFO_PART_END = 7'h53;
  localparam logic [6:0] INFO_CAL = 7'h60;
  localparam logic [7:0] INFO_RSVD_BYTE = 8'hFF;
  localparam logic [7:0] PART_ID_PAD = 8'h0F;
  localparam int PART_ID_LEN = 20;
  // variant straps, largest first
  localparam logic [1:0] VAR_8K = 2'h0;
  localparam logic [1:0] VAR_4K = 2'h1;
  localparam logic [1:0] VAR_2K = 2'h2;
  localparam logic [1:0] VAR_1K = 2'h3;

  typedef enum logic [3:0] {
    MASD_SLOT_OPTION,
    MASD_SLOT_RESET_VEC,
    MASD_SLOT_WATCHDOG_VECTOR_SLOT,
    MASD_SLOT_ILL_TRAP,
    MASD_SLOT_IRQ_VEC,
    MASD_SLOT_OSC_TRAP,
    MASD_SLOT_CODE,
    MASD_SLOT_UNIMPL,
    MASD_SLOT_INFO
  } masd_slot_t;
endpackage

module masd_info_rom
  import masd_pkg::*;
#(
  // option bytes, 64 bytes, byte 0 in the top bits; value arbitrary
  parameter logic [511:0] OPTION_BYTES = {64{8'hFF}},
  // part identifier, 20 ASCII characters, first in the top bits; value arbitrary
  parameter logic [159:0] PART_ID = {"MASD-DEMO", {11{8'h0F}}},
  // calibration, 32 bytes, byte 0 in the top bits; value arbitrary
  parameter logic [255:0] CAL_BYTES = {32{8'hFF}}
)(
  // lookup
  input wire logic [6:0] i_index,
  output logic [7:0] o_byte
);
  logic [8:0] bitpos;

  // constant lookup, no write path exists so contents never change
  always_comb
  begin
    bitpos = 9'h000;
    o_byte = INFO_RSVD_BYTE;
    if (i_index < INFO_PART_ID)
    begin
      bitpos = 9'(i_index) * 9'h008;
      o_byte = OPTION_BYTES[511 - 32'(bitpos) -: 8];
    end
    else if (i_index <= INFO_PART_END)
    begin
      bitpos = 9'(i_index - INFO_PART_ID) * 9'h008;
      o_byte = PART_ID[159 - 32'(bitpos) -: 8];
    end
    else if (i_index >= INFO_CAL)
    begin
      bitpos = 9'(i_index - INFO_CAL) * 9'h008;
      o_byte = CAL_BYTES[255 - 32'(bitpos) -: 8];
    end
  end
endmodule

// file: masd_top.sv
// register file, program memory and data memory address decoding
`timescale 1ns/1ps

module masd_top
  import masd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // variant strap, static logic level on this clock
  input wire logic [1:0] i_variant,
  // register file access from the core
  input wire logic [11:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // control page toward peripherals
  output logic o_ctrl_rd,
  output logic o_ctrl_wr,
  output logic [7:0] o_ctrl_addr,
  output logic [7:0] o_ctrl_wdata,
  input wire logic [7:0] i_ctrl_rdata,
  input wire logic i_ctrl_hit,
  // program memory access from the core
  input wire logic [15:0] i_prog_addr,
  input wire logic i_prog_rd,
  input wire logic i_prog_wr,
  input wire logic [7:0] i_prog_wdata,
  output logic [7:0] o_prog_rdata,
  output logic o_prog_rvalid,
  output masd_slot_t o_prog_slot,
  // flash array port
  output logic o_flash_rd,
  output logic o_flash_wr,
  output logic [12:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  input wire logic [7:0] i_flash_rdata,
  // information area enable, page-select bit 7
  input wire logic i_info_en,
  // data memory space access from the core
  input wire logic [15:0] i_data_addr,
  input wire logic i_data_rd,
  output logic o_data_hit
);
  typedef struct packed {
    logic strap_done;
    logic [1:0] variant;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [7:0] prog_rdata;
    logic prog_rvalid;
    masd_slot_t prog_slot;
  } masd_state_t;

  masd_state_t st;
  masd_state_t next_st;
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] ram_rbyte;
  logic [7:0] info_byte;
  logic reg_is_ctrl;
  logic reg_is_ram;
  logic prog_in_flash;
  logic prog_in_info;

  // last implemented RAM address for a variant
  function automatic logic [11:0] ram_end(input logic [1:0] v);
    unique case (v)
      VAR_8K, VAR_4K: ram_end = RAM_END_BIG;
      VAR_2K: ram_end = RAM_END_MID;
      VAR_1K: ram_end = RAM_END_SMALL;
    endcase
  endfunction

  // last implemented flash address for a variant
  function automatic logic [15:0] flash_end(input logic [1:0] v);
    unique case (v)
      VAR_8K, VAR_4K: flash_end = FLASH_END_BIG;
      VAR_2K: flash_end = FLASH_END_MID;
      VAR_1K: flash_end = FLASH_END_SMALL;
    endcase
  endfunction

  // fixed slot of a program address inside flash
  function automatic masd_slot_t slot_of(input logic [15:0] a);
    if (a < SLOT_RESET_VEC)
      slot_of = MASD_SLOT_OPTION;
    else if (a < SLOT_WDOG_VEC)
      slot_of = MASD_SLOT_RESET_VEC;
    else if (a < SLOT_ILL_TRAP)
      slot_of = MASD_SLOT_WATCHDOG_VECTOR_SLOT;
    else if (a < SLOT_IRQ_VEC)
      slot_of = MASD_SLOT_ILL_TRAP;
    else if (a < SLOT_OSC_TRAP)
      slot_of = MASD_SLOT_IRQ_VEC;
    else if (a < SLOT_CODE)
      slot_of = MASD_SLOT_OSC_TRAP;
    else
      slot_of = MASD_SLOT_CODE;
  endfunction

  // register file decode: whole 12-bit space covered
  assign reg_is_ctrl = (i_reg_addr >= REG_CTRL_BASE);
  assign reg_is_ram = (i_reg_addr <= ram_end(st.variant));

  // control page strobes pass straight through, reserved ones too
  assign o_ctrl_rd = i_reg_rd && reg_is_ctrl;
  assign o_ctrl_wr = i_reg_wr && reg_is_ctrl;
  assign o_ctrl_addr = i_reg_addr[7:0];
  assign o_ctrl_wdata = i_reg_wdata;

  // program decode; overlay only when enabled
  assign prog_in_info = i_info_en && (i_prog_addr >= INFO_BASE)
    && (i_prog_addr <= INFO_LAST);
  assign prog_in_flash = (i_prog_addr <= flash_end(st.variant));

  // flash strobes only for implemented addresses
  assign o_flash_rd = i_prog_rd && prog_in_flash && !prog_in_info;
  assign o_flash_wr = i_prog_wr && prog_in_flash;
  assign o_flash_addr = i_prog_addr[12:0];
  assign o_flash_wdata = i_prog_wdata;

  // no storage answers in data memory space
  assign o_data_hit = 1'b0;

  // information area contents
  masd_info_rom u_info (
    .i_index(i_prog_addr[6:0]),
    .o_byte(info_byte)
  );

  // on-chip RAM, writes only inside the implemented size
  always_ff @(posedge i_clk)
  begin
    if (i_reg_wr && reg_is_ram && !reg_is_ctrl)
      ram[i_reg_addr[9:0]] <= i_reg_wdata;
  end
  assign ram_rbyte = ram[i_reg_addr[9:0]];

  // next state: strap capture and registered read answers
  always_comb
  begin
    next_st = st;
    next_st.strap_done = 1'b1;
    if (!st.strap_done)
      next_st.variant = i_variant;
    next_st.reg_rvalid = i_reg_rd;
    if (i_reg_rd)
    begin
      if (reg_is_ctrl)
        next_st.reg_rdata = i_ctrl_hit ? i_ctrl_rdata : REG_UNDEF_BYTE;
      else if (reg_is_ram)
        next_st.reg_rdata = ram_rbyte;
      else
        next_st.reg_rdata = REG_UNDEF_BYTE;
    end
    next_st.prog_rvalid = i_prog_rd;
    if (i_prog_rd)
    begin
      if (prog_in_info)
      begin
        next_st.prog_rdata = (i_prog_addr - INFO_BASE < 16'(INFO_SIZE))
          ? info_byte : INFO_RSVD_BYTE;
        next_st.prog_slot = MASD_SLOT_INFO;
      end
      else if (prog_in_flash)
      begin
        next_st.prog_rdata = i_flash_rdata;
        next_st.prog_slot = slot_of(i_prog_addr);
      end
      else
      begin
        next_st.prog_rdata = PROG_UNIMPL_BYTE;
        next_st.prog_slot = MASD_SLOT_UNIMPL;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st.strap_done <= 1'b0;
      st.variant <= VAR_8K;
      st.reg_rdata <= REG_UNDEF_BYTE;
      st.reg_rvalid <= 1'b0;
      st.prog_rdata <= PROG_UNIMPL_BYTE;
      st.prog_rvalid <= 1'b0;
      st.prog_slot <= MASD_SLOT_OPTION;
    end
    else
      st <= next_st;
  end

  // outputs from the state register
  assign o_reg_rdata = st.reg_rdata;
  assign o_reg_rvalid = st.reg_rvalid;
  assign o_prog_rdata = st.prog_rdata;
  assign o_prog_rvalid = st.prog_rvalid;
  assign o_prog_slot = st.prog_slot;

  // checks
  ctrl_page_select_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd || i_reg_wr) |-> ((o_ctrl_rd || o_ctrl_wr) == (i_reg_addr[11:8] == 4'hF)))
    else $error("control page select wrong");
  reg_gap_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && i_reg_addr < REG_CTRL_BASE && i_reg_addr > ram_end(st.variant))
    |=> (o_reg_rvalid && o_reg_rdata == REG_UNDEF_BYTE))
    else $error("gap read not undefined byte");
  ram_size_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && i_reg_addr <= 12'h0FF) |=> (o_reg_rdata == $past(ram_rbyte)))
    else $error("smallest ram range not read back");
  prog_unimpl_ff_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && !prog_in_info && i_prog_addr > flash_end(st.variant))
    |=> (o_prog_rdata == 8'hFF && o_prog_slot == MASD_SLOT_UNIMPL))
    else $error("unimplemented program read not FFH");
  prog_write_guard_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_flash_wr |-> (i_prog_addr <= flash_end(st.variant) && i_prog_wr))
    else $error("flash write outside implemented flash");
  slot_watchdog_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr[15:1] == 15'h0002)
    |=> (o_prog_slot == MASD_SLOT_WATCHDOG_VECTOR_SLOT))
    else $error("watchdog vector slot decoded wrong");
  flash_end_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st.strap_done && st.variant == VAR_1K && i_prog_rd && i_prog_addr == 16'h0400)
    |=> o_prog_rdata == 8'hFF)
    else $error("smallest variant flash end wrong");
  data_space_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_data_rd |-> ##[0:2] !o_data_hit)
    else $error("data space answered");
  info_overlay_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_info_en && i_prog_addr >= 16'hFE00 && i_prog_addr <= 16'hFE7F)
    |=> (o_prog_rdata == $past(info_byte) && o_prog_slot == MASD_SLOT_INFO))
    else $error("info overlay not returned");
  info_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && !i_info_en && i_prog_addr >= INFO_BASE)
    |=> (o_prog_slot != MASD_SLOT_INFO))
    else $error("info area reached while disabled");
  info_readonly_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_wr && i_prog_addr >= INFO_BASE) |-> !o_flash_wr)
    else $error("write reached info window");
  part_pad_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_info_en && i_prog_addr == 16'hFE53) |=> o_prog_rdata == PART_ID_PAD)
    else $error("part id not padded");

  // answer timing, pass-through data and slot table checks
  reg_answer_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_reg_rd |=> o_reg_rvalid)
    else $error("register read not answered");
  reg_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_reg_rd |=> !o_reg_rvalid)
    else $error("register answer without read");
  ctrl_read_pass_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && reg_is_ctrl && i_ctrl_hit) |=> (o_reg_rdata == $past(i_ctrl_rdata)))
    else $error("control page read data lost");
  ctrl_reserved_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && reg_is_ctrl && !i_ctrl_hit) |=> (o_reg_rdata == REG_UNDEF_BYTE))
    else $error("reserved control read not undefined byte");
  prog_answer_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_prog_rd |=> o_prog_rvalid)
    else $error("program read not answered");
  prog_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_prog_rd |=> !o_prog_rvalid)
    else $error("program answer without read");
  flash_read_guard_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_flash_rd |-> (i_prog_rd && i_prog_addr <= flash_end(st.variant)))
    else $error("flash read outside implemented flash");
  flash_data_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_flash_rd |=> (o_prog_rdata == $past(i_flash_rdata)))
    else $error("flash read data lost");
  slot_option_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr[15:1] == 15'h0000) |=> (o_prog_slot == MASD_SLOT_OPTION))
    else $error("option slot decoded wrong");
  slot_reset_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr[15:1] == 15'h0001) |=> (o_prog_slot == MASD_SLOT_RESET_VEC))
    else $error("reset vector slot decoded wrong");
  slot_trap_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr[15:1] == 15'h0003) |=> (o_prog_slot == MASD_SLOT_ILL_TRAP))
    else $error("illegal instruction slot decoded wrong");
  slot_irq_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr >= SLOT_IRQ_VEC && i_prog_addr < SLOT_OSC_TRAP)
    |=> (o_prog_slot == MASD_SLOT_IRQ_VEC))
    else $error("interrupt vector slot decoded wrong");
  slot_osc_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr >= SLOT_OSC_TRAP && i_prog_addr < SLOT_CODE)
    |=> (o_prog_slot == MASD_SLOT_OSC_TRAP))
    else $error("oscillator trap slot decoded wrong");
  slot_code_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_prog_addr >= SLOT_CODE && i_prog_addr <= flash_end(st.variant))
    |=> (o_prog_slot == MASD_SLOT_CODE))
    else $error("code slot decoded wrong");
  strap_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st.strap_done |=> $stable(st.variant))
    else $error("variant changed after capture");
  info_reserved_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_prog_rd && i_info_en && i_prog_addr >= 16'hFE80 && i_prog_addr <= INFO_LAST)
    |=> (o_prog_rdata == INFO_RSVD_BYTE && o_prog_slot == MASD_SLOT_INFO))
    else $error("reserved info byte wrong");
endmodule

// file: masd_far_model.sv
// flash array and peripheral page stand-in facing the decoder
`timescale 1ns/1ps

module masd_far_model (
  // flash array side
  input wire logic i_flash_rd,
  input wire logic [12:0] i_flash_addr,
  output logic [7:0] o_flash_rdata,
  // peripheral page side
  input wire logic i_ctrl_rd,
  input wire logic [7:0] i_ctrl_addr,
  output logic [7:0] o_ctrl_rdata,
  output logic o_ctrl_hit
);
  logic [7:0] flash_byte;

  // flash pattern; an unselected array shows the inverse, not stale data
  always_comb
  begin
    flash_byte = i_flash_addr[7:0] ^ {3'h0, i_flash_addr[12:8]} ^ 8'h5A;
    o_flash_rdata = i_flash_rd ? flash_byte : ~flash_byte;
  end

  // page slots 10-3F have no register and answer without hit
  always_comb
  begin
    o_ctrl_hit = i_ctrl_rd && !(i_ctrl_addr >= 8'h10 && i_ctrl_addr < 8'h40);
    o_ctrl_rdata = i_ctrl_rd ? ~i_ctrl_addr : i_ctrl_addr;
  end
endmodule

// file: mcu_address_space_decoder_test.sv
// self-checking bench for the address space decoder
`timescale 1ns/1ps

module mcu_address_space_decoder_test;
  import masd_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] i_variant = 2'h0;
  logic [11:0] i_reg_addr = 12'h000;
  logic i_reg_rd = 1'b0;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata, o_ctrl_addr, o_ctrl_wdata, i_ctrl_rdata, o_prog_rdata;
  logic o_reg_rvalid, o_ctrl_rd, o_ctrl_wr, i_ctrl_hit, o_prog_rvalid;
  logic [15:0] i_prog_addr = 16'h0000;
  logic i_prog_rd = 1'b0;
  logic i_prog_wr = 1'b0;
  logic [7:0] i_prog_wdata = 8'h00;
  masd_slot_t o_prog_slot;
  logic o_flash_rd, o_flash_wr, o_data_hit;
  logic [12:0] o_flash_addr;
  logic [7:0] o_flash_wdata, i_flash_rdata;
  logic i_info_en = 1'b0;
  logic [15:0] i_data_addr = 16'h0000;
  logic i_data_rd = 1'b0;
  int bad_count = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  masd_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_variant(i_variant),
    .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_ctrl_rd(o_ctrl_rd), .o_ctrl_wr(o_ctrl_wr), .o_ctrl_addr(o_ctrl_addr),
    .o_ctrl_wdata(o_ctrl_wdata), .i_ctrl_rdata(i_ctrl_rdata), .i_ctrl_hit(i_ctrl_hit),
    .i_prog_addr(i_prog_addr), .i_prog_rd(i_prog_rd), .i_prog_wr(i_prog_wr),
    .i_prog_wdata(i_prog_wdata), .o_prog_rdata(o_prog_rdata),
    .o_prog_rvalid(o_prog_rvalid), .o_prog_slot(o_prog_slot), .o_flash_rd(o_flash_rd),
    .o_flash_wr(o_flash_wr), .o_flash_addr(o_flash_addr), .o_flash_wdata(o_flash_wdata),
    .i_flash_rdata(i_flash_rdata), .i_info_en(i_info_en), .i_data_addr(i_data_addr),
    .i_data_rd(i_data_rd), .o_data_hit(o_data_hit));

  masd_far_model far (.i_flash_rd(o_flash_rd), .i_flash_addr(o_flash_addr),
    .o_flash_rdata(i_flash_rdata), .i_ctrl_rd(o_ctrl_rd), .i_ctrl_addr(o_ctrl_addr),
    .o_ctrl_rdata(i_ctrl_rdata), .o_ctrl_hit(i_ctrl_hit));

  // shared comparison
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // flash pattern of the far model
  function automatic logic [7:0] fx(input logic [15:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5A;
  endfunction

  // reset with a strap value, then let the capture edge pass
  task automatic do_reset(input logic [1:0] v);
    i_rstn = 1'b0;
    i_variant = v;
    repeat (8) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    @(posedge i_clk);
  endtask

  // register write; page strobe expected only at F00-FFF
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    #1 chk("ctrl wr", {15'h0, a[11:8] == 4'hF}, {15'h0, o_ctrl_wr});
    chk("ctrl wdata", {8'h0, d}, {8'h0, o_ctrl_wdata});
    chk("ctrl addr", {8'h0, a[7:0]}, {8'h0, o_ctrl_addr});
    @(posedge i_clk);
    #1 i_reg_wr = 1'b0;
  endtask

  // register read, answer one cycle later
  task automatic reg_read(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clk);
    #1 i_reg_addr = a;
    i_reg_rd = 1'b1;
    #1 chk("ctrl rd", {15'h0, a[11:8] == 4'hF}, {15'h0, o_ctrl_rd});
    @(posedge i_clk);
    #1 i_reg_rd = 1'b0;
    chk("reg rvalid", 16'h0001, {15'h0, o_reg_rvalid});
    chk("reg rdata", {8'h0, e}, {8'h0, o_reg_rdata});
  endtask

  // program read with flash strobe, data and slot
  task automatic prog_read(input logic [15:0] a, input logic [7:0] e, input masd_slot_t s,
    input logic frd);
    @(posedge i_clk);
    #1 i_prog_addr = a;
    i_prog_rd = 1'b1;
    #1 chk("flash rd", {15'h0, frd}, {15'h0, o_flash_rd});
    @(posedge i_clk);
    #1 i_prog_rd = 1'b0;
    chk("prog rvalid", 16'h0001, {15'h0, o_prog_rvalid});
    chk("prog rdata", {8'h0, e}, {8'h0, o_prog_rdata});
    chk("prog slot", {12'h0, s}, {12'h0, o_prog_slot});
  endtask

  // program write, flash strobe only inside flash
  task automatic prog_write(input logic [15:0] a, input logic fwr);
    @(posedge i_clk);
    #1 i_prog_addr = a;
    i_prog_wdata = 8'hC3;
    i_prog_wr = 1'b1;
    #1 chk("flash wr", {15'h0, fwr}, {15'h0, o_flash_wr});
    chk("flash wdata", 16'h00C3, {8'h0, o_flash_wdata});
    chk("flash addr", {3'h0, a[12:0]}, {3'h0, o_flash_addr});
    @(posedge i_clk);
    #1 i_prog_wr = 1'b0;
  endtask

  // ram, gap and page decoding of the largest part
  task automatic test_regs();
    reg_write(12'h000, 8'hA5);
    reg_write(12'h3FF, 8'h3C);
    reg_write(12'h400, 8'h77);
    reg_write(12'hF00, 8'h11);
    reg_read(12'h000, 8'hA5);
    reg_read(12'h3FF, 8'h3C);
    reg_read(12'h400, REG_UNDEF_BYTE);
    reg_read(12'hEFF, REG_UNDEF_BYTE);
    reg_read(12'hF05, 8'hFA);
    reg_read(12'hFFE, 8'h01);
    reg_read(12'hF20, REG_UNDEF_BYTE);
  endtask

  // slot table, flash end and data space
  task automatic test_prog();
    logic [15:0] pa [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0006, 16'h0008,
      16'h0037, 16'h0038, 16'h003D, 16'h003E, 16'h0FFF};
    masd_slot_t ps [11] = '{MASD_SLOT_OPTION, MASD_SLOT_OPTION, MASD_SLOT_RESET_VEC,
      MASD_SLOT_WATCHDOG_VECTOR_SLOT, MASD_SLOT_ILL_TRAP, MASD_SLOT_IRQ_VEC,
      MASD_SLOT_IRQ_VEC, MASD_SLOT_OSC_TRAP, MASD_SLOT_OSC_TRAP, MASD_SLOT_CODE,
      MASD_SLOT_CODE};
    i_data_addr = 16'h0010;
    i_data_rd = 1'b1;
    for (int k = 0; k < 11; k++)
      prog_read(pa[k], fx(pa[k]), ps[k], 1'b1);
    prog_read(16'h1000, 8'hFF, MASD_SLOT_UNIMPL, 1'b0);
    prog_read(16'hFFFF, 8'hFF, MASD_SLOT_UNIMPL, 1'b0);
    chk("data hit", 16'h0000, {15'h0, o_data_hit});
    i_data_rd = 1'b0;
    prog_write(16'h0100, 1'b1);
    prog_write(16'h1000, 1'b0);
  endtask

  // overlay contents, read-only and disabled decoding
  task automatic test_info();
    logic [15:0] ia [8] = '{16'hFE00, 16'hFE40, 16'hFE48, 16'hFE49, 16'hFE53, 16'hFE54,
      16'hFE60, 16'hFF7F};
    logic [7:0] ie [8] = '{8'hFF, 8'h4D, 8'h4F, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
    i_info_en = 1'b1;
    for (int k = 0; k < 8; k++)
      prog_read(ia[k], ie[k], MASD_SLOT_INFO, 1'b0);
    prog_write(16'hFE40, 1'b0);
    prog_read(16'hFE40, 8'h4D, MASD_SLOT_INFO, 1'b0);
    i_info_en = 1'b0;
    prog_read(16'hFE40, 8'hFF, MASD_SLOT_UNIMPL, 1'b0);
  endtask

  // 2K and 1K variants move ram and flash ends; 4K keeps the largest ones
  task automatic test_variants();
    do_reset(VAR_2K);
    reg_write(12'h1FF, 8'h66);
    reg_write(12'h200, 8'h55);
    reg_read(12'h1FF, 8'h66);
    reg_read(12'h200, REG_UNDEF_BYTE);
    prog_read(16'h07FF, fx(16'h07FF), MASD_SLOT_CODE, 1'b1);
    prog_read(16'h0800, 8'hFF, MASD_SLOT_UNIMPL, 1'b0);
    do_reset(VAR_1K);
    reg_write(12'h100, 8'h55);
    reg_read(12'h100, REG_UNDEF_BYTE);
    prog_read(16'h03FF, fx(16'h03FF), MASD_SLOT_CODE, 1'b1);
    prog_read(16'h0400, 8'hFF, MASD_SLOT_UNIMPL, 1'b0);
    do_reset(VAR_4K);
    reg_read(12'h3FF, 8'h3C);
    reg_read(12'h400, REG_UNDEF_BYTE);
    prog_read(16'h0FFF, fx(16'h0FFF), MASD_SLOT_CODE, 1'b1);
    prog_read(16'h1000, 8'hFF, MASD_SLOT_UNIMPL, 1'b0);
  endtask

  // counts and verdict, then stop
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    do_reset(VAR_8K);
    test_regs();
    test_prog();
    test_info();
    test_variants();
    print_verdict();
  end

  // hang guard, far beyond the roughly 140 cycles of the run
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
